// >>> verilog/uep_pkg.sv
/*
  Package for the USB endpoint control/status block: register offsets,
  field positions, reset values and sizes.
  Assumes byte-wide registers on a plain CPU port, one clock domain.
*/
package uep_pkg;
  // register offsets (byte addresses on the CPU port)
  localparam logic [7:0] OFS_EP_SELECT = 8'h0E;
  localparam logic [7:0] OFS_IN_MAXPKT = 8'h10;
  localparam logic [7:0] OFS_IN_CTRL1  = 8'h11;
  localparam logic [7:0] OFS_IN_CTRL2  = 8'h12;
  localparam logic [7:0] OFS_OUT_LIMIT = 8'h13;
  localparam logic [7:0] OFS_OUT_CTRL1 = 8'h14;
  localparam logic [7:0] OFS_OUT_CTRL2 = 8'h15;
  // in_endpoint_control1 fields
  localparam int IC1_RST_TOG  = 6;
  localparam int IC1_STALLED  = 5;
  localparam int IC1_STALL    = 4;
  localparam int IC1_FLUSH    = 3;
  localparam int IC1_UNDERRUN = 2;
  localparam int IC1_OCCUPIED = 1;
  localparam int IC1_READY    = 0;
  // in_endpoint_control2 fields
  localparam int IC2_AUTO     = 7;
  localparam int IC2_ISO      = 6;
  localparam int IC2_DIR      = 5;
  localparam int IC2_DMA      = 4;
  localparam int IC2_FORCE    = 3;
  // out_endpoint_control1 fields
  localparam int OC1_RST_TOG  = 7;
  localparam int OC1_STALLED  = 6;
  localparam int OC1_STALL    = 5;
  localparam int OC1_FLUSH    = 4;
  localparam int OC1_DATA_ERR = 3;
  localparam int OC1_OVERRUN  = 2;
  localparam int OC1_FULL     = 1;
  localparam int OC1_READY    = 0;
  // out_endpoint_control2 field
  localparam int OC2_ISO      = 6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // sizes
  localparam int NUM_EP      = 3;
  localparam int FIFO_PKTS   = 2;
  localparam int MAXPKT_UNIT = 8;
endpackage

// >>> verilog/uep_endpoint_csr.sv
/*
  Control and status logic for IN/OUT endpoints 1..3 of a full-speed USB
  device: stall, toggles, flush, packet-ready handshakes, iso mode, DMA
  request enable, underrun/overrun/error flags.
  Assumes the serial engine reports handshakes and packet events as
  one-cycle pulses on this clock, tagged with an endpoint number.
*/
// Implementation choice: strobed register access.
// Behaviour
// - writing one to IN reset_data_toggle clears that endpoint's IN toggle.
// - after IN STALL sent, set stall flag, flush FIFO, clear ready; read clears. (no flush here if a packet loads in that same cycle)
// - IN send_stall answers tokens with STALL until cleared; no effect in iso.
// - IN flush drops next packet, clears ready, self-clears; two writes for two.
// - underrun flag on iso zero-length send or bulk NAK; read clears it.
// - in_queue_occupied reads one while IN FIFO holds a packet.
// - CPU sets IN ready after loading; device clears it after transmission, pulses irq.
// - auto_in_ready sets IN ready when a full max-size packet is loaded.
// - IN isochronous_select picks iso when set, bulk/interrupt when clear.
// - shared FIFO endpoint is IN when direction select set, OUT when clear.
// - IN DMA requests only while in_dma_request_enable is set.
// - force_toggle_switch flips IN toggle and drops current packet regardless of ACK.
// - writing one to OUT reset_data_toggle clears that endpoint's OUT toggle.
// - OUT stall flag set on STALL sent; read clears it.
// - OUT send_stall returns STALL until cleared; ignored in iso mode.
// - OUT flush drops next packet to read, self-clears; two writes for two.
// - iso OUT data error set with ready on bad CRC, clears with ready.
// - iso OUT overrun flag set when packet cannot be stored; CPU clears.
// - out_queue_saturated reads one while OUT FIFO cannot take another packet.
// - device sets OUT ready and pulses irq on receipt; CPU clears after unload.
// - each IN endpoint has its own register copy, selected one visible.
// - four-bit endpoint_selector picks which endpoint's register set is mapped.
`timescale 1ns/100ps
module uep_endpoint_csr #(
  parameter int NEP = uep_pkg::NUM_EP
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // cpu register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // serial engine events, IN side (one-cycle pulses)
  input  wire logic [1:0] in_ev_ep,
  input  wire logic       in_ev_token,
  input  wire logic       in_ev_sent,
  input  wire logic       in_ev_loaded,
  input  wire logic       in_ev_full_pkt,
  // serial engine events, OUT side (one-cycle pulses)
  input  wire logic [1:0] out_ev_ep,
  input  wire logic       out_ev_token,
  input  wire logic       out_ev_rcvd,
  input  wire logic       out_ev_crc_err,
  input  wire logic       out_ev_unloaded,
  // handshake decisions and status toward the engine
  output logic            in_stall_ans,
  output logic            in_nak_ans,
  output logic            in_zlp_ans,
  output logic            out_stall_ans,
  output logic            out_nak_ans,
  output logic [NEP-1:0]  in_toggle,
  output logic [NEP-1:0]  out_toggle,
  output logic [NEP-1:0]  in_dir,
  output logic [NEP-1:0]  in_dma_req,
  output logic            in_done_irq,
  output logic            out_rcvd_irq
);
  localparam int PW = $clog2(uep_pkg::FIFO_PKTS + 1);
  localparam logic [PW-1:0] PKTS = PW'(uep_pkg::FIFO_PKTS);

  logic [3:0]    sel_reg;
  logic [7:0]    in_max_reg  [NEP];
  logic [7:0]    out_max_reg [NEP];
  logic [NEP-1:0] in_stall_reg, in_stalled_reg, in_under_reg, in_rdy_reg;
  logic [NEP-1:0] in_auto_reg, in_iso_reg, in_dir_reg, in_dma_reg;
  logic [NEP-1:0] in_tog_reg, out_tog_reg;
  logic [NEP-1:0] out_stall_reg, out_stalled_reg, out_err_reg, out_ovr_reg;
  logic [NEP-1:0] out_rdy_reg, out_iso_reg;
  logic [PW-1:0] in_cnt_reg  [NEP];
  logic [PW-1:0] out_cnt_reg [NEP];

  // selected endpoint 1..3 maps to index 0..2; other values map nothing
  logic       sel_ok;
  logic [1:0] si;
  assign sel_ok = (sel_reg >= 4'h1) && (sel_reg <= 4'(NEP));
  assign si     = 2'(sel_reg - 4'h1);

  logic w_sel, w_imax, w_ic1, w_ic2, w_olim, w_oc1, w_oc2, r_ic1, r_oc1;
  always_comb
  begin
    w_sel  = 1'b0;
    w_imax = 1'b0;
    w_ic1  = 1'b0;
    w_ic2  = 1'b0;
    w_olim = 1'b0;
    w_oc1  = 1'b0;
    w_oc2  = 1'b0;
    if (addr == uep_pkg::OFS_EP_SELECT)
      w_sel = wr;
    else if (addr == uep_pkg::OFS_IN_MAXPKT)
      w_imax = wr && sel_ok;
    else if (addr == uep_pkg::OFS_IN_CTRL1)
      w_ic1 = wr && sel_ok;
    else if (addr == uep_pkg::OFS_IN_CTRL2)
      w_ic2 = wr && sel_ok;
    else if (addr == uep_pkg::OFS_OUT_LIMIT)
      w_olim = wr && sel_ok;
    else if (addr == uep_pkg::OFS_OUT_CTRL1)
      w_oc1 = wr && sel_ok;
    else if (addr == uep_pkg::OFS_OUT_CTRL2)
      w_oc2 = wr && sel_ok;
  end
  assign r_ic1 = rd && sel_ok && (addr == uep_pkg::OFS_IN_CTRL1);
  assign r_oc1 = rd && sel_ok && (addr == uep_pkg::OFS_OUT_CTRL1);

  always_ff @(posedge clock)
  begin
    if (rst)
      sel_reg <= 4'h0;
    else if (w_sel)
      sel_reg <= wdata[3:0];
  end

  // per-endpoint state; each index is its own register copy
  for (genvar e = 0; e < NEP; e++)
  begin : g_ep
    logic me_sel, in_ev, out_ev, in_iso, out_iso;
    logic in_flush, in_force, in_stall_tx, in_under, in_pop, in_push;
    logic out_flush, out_stall_tx, out_store, out_lost, out_pop;
    assign me_sel  = sel_ok && (si == 2'(e));
    assign in_ev   = (in_ev_ep == 2'(e));
    assign out_ev  = (out_ev_ep == 2'(e));
    assign in_iso  = in_iso_reg[e];
    assign out_iso = out_iso_reg[e];

    assign in_flush    = w_ic1 && me_sel && wdata[uep_pkg::IC1_FLUSH];
    assign in_force    = w_ic2 && me_sel && wdata[uep_pkg::IC2_FORCE];
    assign in_stall_tx = in_ev && in_ev_token && in_stall_reg[e] && !in_iso;
    assign in_under    = in_ev && in_ev_token && !in_stall_tx
                         && !in_rdy_reg[e];
    assign in_pop      = (in_ev && in_ev_sent) || in_flush || in_force;
    assign in_push     = in_ev && in_ev_loaded && in_cnt_reg[e] != PKTS;
    assign out_flush   = w_oc1 && me_sel && wdata[uep_pkg::OC1_FLUSH];
    assign out_stall_tx = out_ev && out_ev_token && out_stall_reg[e] && !out_iso;
    assign out_store   = out_ev && out_ev_rcvd && out_cnt_reg[e] != PKTS;
    assign out_lost    = out_ev && out_ev_rcvd && out_cnt_reg[e] == PKTS;
    assign out_pop     = (out_ev && out_ev_unloaded) || out_flush;

    // packet counters stand in for FIFO occupancy
    always_ff @(posedge clock)
    begin
      if (rst || (in_stall_tx && !in_push))
        in_cnt_reg[e] <= '0;
      else if (in_push && !(in_pop && in_cnt_reg[e] != '0))
        in_cnt_reg[e] <= in_cnt_reg[e] + PW'(1);
      else if (!in_push && in_pop && in_cnt_reg[e] != '0)
        in_cnt_reg[e] <= in_cnt_reg[e] - PW'(1);
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        out_cnt_reg[e] <= '0;
      else if (out_store && !(out_pop && out_cnt_reg[e] != '0))
        out_cnt_reg[e] <= out_cnt_reg[e] + PW'(1);
      else if (!out_store && out_pop && out_cnt_reg[e] != '0)
        out_cnt_reg[e] <= out_cnt_reg[e] - PW'(1);
    end

    // IN packet ready: hardware clear on send/flush/stall; set by cpu or auto
    always_ff @(posedge clock)
    begin
      if (rst)
        in_rdy_reg[e] <= 1'b0;
      else if ((in_ev && in_ev_sent) || in_flush || in_stall_tx || in_force)
        in_rdy_reg[e] <= 1'b0;
      else if (w_ic1 && me_sel && wdata[uep_pkg::IC1_READY])
        in_rdy_reg[e] <= 1'b1;
      else if (in_auto_reg[e] && in_ev && in_ev_full_pkt)
        in_rdy_reg[e] <= 1'b1;
    end

    // sticky flags: set wins over read-clear
    always_ff @(posedge clock)
    begin
      if (rst)
        in_stalled_reg[e] <= 1'b0;
      else if (in_stall_tx)
        in_stalled_reg[e] <= 1'b1;
      else if (r_ic1 && me_sel)
        in_stalled_reg[e] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        in_under_reg[e] <= 1'b0;
      else if (in_under)
        in_under_reg[e] <= 1'b1;
      else if (r_ic1 && me_sel)
        in_under_reg[e] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        in_tog_reg[e] <= 1'b0;
      else if (w_ic1 && me_sel && wdata[uep_pkg::IC1_RST_TOG])
        in_tog_reg[e] <= 1'b0;
      else if (in_force || (in_ev && in_ev_sent))
        in_tog_reg[e] <= !in_tog_reg[e];
    end

    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        in_stall_reg[e] <= 1'b0;
        in_auto_reg[e]  <= 1'b0;
        in_iso_reg[e]   <= 1'b0;
        in_dir_reg[e]   <= 1'b0;
        in_dma_reg[e]   <= 1'b0;
        in_max_reg[e]   <= uep_pkg::RST_BYTE;
        out_max_reg[e]  <= uep_pkg::RST_BYTE;
        out_stall_reg[e] <= 1'b0;
        out_iso_reg[e]  <= 1'b0;
      end
      else
      begin
        if (w_ic1 && me_sel)
          in_stall_reg[e] <= wdata[uep_pkg::IC1_STALL];
        if (w_ic2 && me_sel)
        begin
          in_auto_reg[e] <= wdata[uep_pkg::IC2_AUTO];
          in_iso_reg[e]  <= wdata[uep_pkg::IC2_ISO];
          in_dir_reg[e]  <= wdata[uep_pkg::IC2_DIR];
          in_dma_reg[e]  <= wdata[uep_pkg::IC2_DMA];
        end
        if (w_imax && me_sel)
          in_max_reg[e] <= wdata;
        if (w_olim && me_sel)
          out_max_reg[e] <= wdata;
        if (w_oc1 && me_sel)
          out_stall_reg[e] <= wdata[uep_pkg::OC1_STALL];
        if (w_oc2 && me_sel)
          out_iso_reg[e] <= wdata[uep_pkg::OC2_ISO];
      end
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        out_tog_reg[e] <= 1'b0;
      else if (w_oc1 && me_sel && wdata[uep_pkg::OC1_RST_TOG])
        out_tog_reg[e] <= 1'b0;
      else if (out_store)
        out_tog_reg[e] <= !out_tog_reg[e];
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        out_stalled_reg[e] <= 1'b0;
      else if (out_stall_tx)
        out_stalled_reg[e] <= 1'b1;
      else if (r_oc1 && me_sel)
        out_stalled_reg[e] <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        out_ovr_reg[e] <= 1'b0;
      else if (out_lost && out_iso)
        out_ovr_reg[e] <= 1'b1;
      else if (w_oc1 && me_sel && !wdata[uep_pkg::OC1_OVERRUN])
        out_ovr_reg[e] <= 1'b0;
    end

    // OUT ready: cpu write of zero clears; a new arrival wins
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        out_rdy_reg[e] <= 1'b0;
        out_err_reg[e] <= 1'b0;
      end
      else if (out_store)
      begin
        out_rdy_reg[e] <= 1'b1;
        out_err_reg[e] <= out_iso && out_ev_crc_err;
      end
      else if ((w_oc1 && me_sel && !wdata[uep_pkg::OC1_READY]) || out_flush)
      begin
        out_rdy_reg[e] <= 1'b0;
        out_err_reg[e] <= 1'b0;
      end
    end

    always_ff @(posedge clock)
    begin
      if (rst)
        in_dma_req[e] <= 1'b0;
      else
        in_dma_req[e] <= in_dma_reg[e] && in_dir_reg[e] && me_sel
                         && in_cnt_reg[e] != PKTS && !in_rdy_reg[e];
    end
  end

  assign in_toggle  = in_tog_reg;
  assign out_toggle = out_tog_reg;
  assign in_dir     = in_dir_reg;

  // handshake decisions, registered for the engine
  logic [1:0] ie, oe;
  assign ie = in_ev_ep;
  assign oe = out_ev_ep;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      in_stall_ans  <= 1'b0;
      in_nak_ans    <= 1'b0;
      in_zlp_ans    <= 1'b0;
      out_stall_ans <= 1'b0;
      out_nak_ans   <= 1'b0;
      in_done_irq   <= 1'b0;
      out_rcvd_irq  <= 1'b0;
    end
    else
    begin
      in_stall_ans  <= in_ev_token && in_stall_reg[ie] && !in_iso_reg[ie];
      in_nak_ans    <= in_ev_token && !in_rdy_reg[ie] && !in_iso_reg[ie]
                       && !in_stall_reg[ie];
      in_zlp_ans    <= in_ev_token && !in_rdy_reg[ie] && in_iso_reg[ie];
      out_stall_ans <= out_ev_token && out_stall_reg[oe] && !out_iso_reg[oe];
      out_nak_ans   <= out_ev_token && !out_iso_reg[oe] && !out_stall_reg[oe]
                       && out_cnt_reg[oe] == PKTS;
      in_done_irq   <= in_ev_sent && in_rdy_reg[ie];
      out_rcvd_irq  <= out_ev_rcvd && out_cnt_reg[oe] != PKTS;
    end
  end

  // read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (!rd)
      rdata <= 8'h00;
    else if (addr == uep_pkg::OFS_EP_SELECT)
      rdata <= {4'h0, sel_reg};
    else if (!sel_ok)
      rdata <= 8'h00;
    else if (addr == uep_pkg::OFS_IN_MAXPKT)
      rdata <= in_max_reg[si];
    else if (addr == uep_pkg::OFS_IN_CTRL1)
      rdata <= {2'b00, in_stalled_reg[si], in_stall_reg[si], 1'b0,
                in_under_reg[si], in_cnt_reg[si] != '0, in_rdy_reg[si]};
    else if (addr == uep_pkg::OFS_IN_CTRL2)
      rdata <= {in_auto_reg[si], in_iso_reg[si], in_dir_reg[si],
                in_dma_reg[si], 4'h0};
    else if (addr == uep_pkg::OFS_OUT_LIMIT)
      rdata <= out_max_reg[si];
    else if (addr == uep_pkg::OFS_OUT_CTRL1)
      rdata <= {1'b0, out_stalled_reg[si], out_stall_reg[si], 1'b0,
                out_err_reg[si], out_ovr_reg[si], out_cnt_reg[si] == PKTS,
                out_rdy_reg[si]};
    else if (addr == uep_pkg::OFS_OUT_CTRL2)
      rdata <= {1'b0, out_iso_reg[si], 6'h00};
    else
      rdata <= 8'h00;
  end
endmodule

// >>> tb/uep_endpoint_csr_props.sv
/*
  Concurrent checks on the ports of the endpoint control/status block.
  Assumes one clock domain and a synchronous active-high reset; bound below.
*/
`timescale 1ns/100ps
module uep_endpoint_csr_props #(
  parameter int NEP = 3
) (
  // clock and reset
  input wire logic           clock,
  input wire logic           rst,
  // cpu port
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [7:0]     rdata,
  // engine events
  input wire logic           in_ev_token,
  input wire logic           in_ev_sent,
  input wire logic           out_ev_token,
  input wire logic           out_ev_rcvd,
  // answers and status
  input wire logic           in_stall_ans,
  input wire logic           in_nak_ans,
  input wire logic           in_zlp_ans,
  input wire logic           out_stall_ans,
  input wire logic           out_nak_ans,
  input wire logic [NEP-1:0] in_toggle,
  input wire logic [NEP-1:0] out_toggle,
  input wire logic           in_done_irq,
  input wire logic           out_rcvd_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data driven outside its slot");
  chk_in_ans_cause: assert property ((in_stall_ans || in_nak_ans || in_zlp_ans) |->
    $past(in_ev_token))
    else $error("IN answer without a token");
  chk_in_one_ans: assert property ($onehot0({in_stall_ans, in_nak_ans, in_zlp_ans}))
    else $error("two IN answers at once");
  chk_out_ans_cause: assert property ((out_stall_ans || out_nak_ans) |->
    $past(out_ev_token) && !(out_stall_ans && out_nak_ans))
    else $error("OUT answer without a token");
  chk_in_irq_cause: assert property (in_done_irq |-> $past(in_ev_sent))
    else $error("IN done pulse without a transmission");
  chk_out_irq_cause: assert property (out_rcvd_irq |-> $past(out_ev_rcvd))
    else $error("OUT pulse without a received packet");
  chk_in_tog_cause: assert property (!$stable(in_toggle) |-> $past(in_ev_sent) || $past(wr))
    else $error("IN toggle moved without cause");
  chk_out_tog_cause: assert property (!$stable(out_toggle) |->
    $past(out_ev_rcvd) || $past(wr))
    else $error("OUT toggle moved without cause");
endmodule

bind uep_endpoint_csr uep_endpoint_csr_props #(.NEP(NEP)) u_uep_endpoint_csr_props (
  .clock(clock), .rst(rst), .wr(wr), .rd(rd), .rdata(rdata),
  .in_ev_token(in_ev_token), .in_ev_sent(in_ev_sent), .out_ev_token(out_ev_token),
  .out_ev_rcvd(out_ev_rcvd), .in_stall_ans(in_stall_ans), .in_nak_ans(in_nak_ans),
  .in_zlp_ans(in_zlp_ans), .out_stall_ans(out_stall_ans), .out_nak_ans(out_nak_ans),
  .in_toggle(in_toggle), .out_toggle(out_toggle), .in_done_irq(in_done_irq),
  .out_rcvd_irq(out_rcvd_irq)
);

// >>> tb/uep_host_model.sv
/*
  Far-side model: the host and serial engine, reduced to event pulses.
  Assumes the bench calls its tasks; each pulse lasts exactly one cycle.
*/
`timescale 1ns/100ps
module uep_host_model (
  // clock
  input  wire logic clock,
  // IN side events
  output logic [1:0] in_ev_ep,
  output logic       in_ev_token,
  output logic       in_ev_sent,
  output logic       in_ev_loaded,
  output logic       in_ev_full_pkt,
  // OUT side events
  output logic [1:0] out_ev_ep,
  output logic       out_ev_token,
  output logic       out_ev_rcvd,
  output logic       out_ev_crc_err,
  output logic       out_ev_unloaded
);
  initial
  begin
    in_ev_ep = 2'h0;
    out_ev_ep = 2'h0;
    {in_ev_full_pkt, in_ev_loaded, in_ev_sent, in_ev_token} = 4'h0;
    {out_ev_unloaded, out_ev_crc_err, out_ev_rcvd, out_ev_token} = 4'h0;
  end

  // kind bits: full-size, loaded, sent, token; index goes stale after the pulse
  task automatic in_ev(input logic [1:0] ep, input logic [3:0] kind);
    @(posedge clock);
    in_ev_ep <= ep;
    {in_ev_full_pkt, in_ev_loaded, in_ev_sent, in_ev_token} <= kind;
    @(posedge clock);
    in_ev_ep <= ~ep;
    {in_ev_full_pkt, in_ev_loaded, in_ev_sent, in_ev_token} <= 4'h0;
  endtask

  // kind bits: unloaded, crc error, received, token
  task automatic out_ev(input logic [1:0] ep, input logic [3:0] kind);
    @(posedge clock);
    out_ev_ep <= ep;
    {out_ev_unloaded, out_ev_crc_err, out_ev_rcvd, out_ev_token} <= kind;
    @(posedge clock);
    out_ev_ep <= ~ep;
    {out_ev_unloaded, out_ev_crc_err, out_ev_rcvd, out_ev_token} <= 4'h0;
  endtask
endmodule

// >>> tb/tb.sv
/*
  Self-checking bench for the endpoint control/status block.
  Assumes a 100 MHz clock, synchronous reset, and the host model for events.
*/
`timescale 1ns/100ps
module tb;
  logic       clock;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [1:0] in_ev_ep, out_ev_ep;
  logic       in_ev_token, in_ev_sent, in_ev_loaded, in_ev_full_pkt;
  logic       out_ev_token, out_ev_rcvd, out_ev_crc_err, out_ev_unloaded;
  logic       in_stall_ans, in_nak_ans, in_zlp_ans, out_stall_ans, out_nak_ans;
  logic       in_done_irq, out_rcvd_irq;
  logic [2:0] in_toggle, out_toggle, in_dir, in_dma_req;
  int         n_errors;
  int         num_checks;

  uep_endpoint_csr u_uep_endpoint_csr (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .in_ev_ep(in_ev_ep), .in_ev_token(in_ev_token), .in_ev_sent(in_ev_sent),
    .in_ev_loaded(in_ev_loaded), .in_ev_full_pkt(in_ev_full_pkt), .out_ev_ep(out_ev_ep),
    .out_ev_token(out_ev_token), .out_ev_rcvd(out_ev_rcvd), .out_ev_crc_err(out_ev_crc_err),
    .out_ev_unloaded(out_ev_unloaded), .in_stall_ans(in_stall_ans), .in_nak_ans(in_nak_ans),
    .in_zlp_ans(in_zlp_ans), .out_stall_ans(out_stall_ans), .out_nak_ans(out_nak_ans),
    .in_toggle(in_toggle), .out_toggle(out_toggle), .in_dir(in_dir),
    .in_dma_req(in_dma_req), .in_done_irq(in_done_irq), .out_rcvd_irq(out_rcvd_irq)
  );

  uep_host_model u_uep_host_model (
    .clock(clock), .in_ev_ep(in_ev_ep), .in_ev_token(in_ev_token),
    .in_ev_sent(in_ev_sent), .in_ev_loaded(in_ev_loaded), .in_ev_full_pkt(in_ev_full_pkt),
    .out_ev_ep(out_ev_ep), .out_ev_token(out_ev_token), .out_ev_rcvd(out_ev_rcvd),
    .out_ev_crc_err(out_ev_crc_err), .out_ev_unloaded(out_ev_unloaded)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample right there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_select();
    wr_reg(8'h11, 8'h10);
    rd_chk(8'h11, 8'h00);
    wr_reg(8'h0E, 8'h01);
    rd_chk(8'h0E, 8'h01);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h14, 8'h00);
    wr_reg(8'h13, 8'h07);
    rd_chk(8'h13, 8'h07);
    $display("test select done");
  endtask

  task automatic t_in_answers();
    u_uep_host_model.in_ev(2'h0, 4'h1);
    #1;
    chk({6'h00, in_nak_ans, in_zlp_ans}, 8'h02);
    rd_chk(8'h11, 8'h04);
    rd_chk(8'h11, 8'h00);
    u_uep_host_model.in_ev(2'h0, 4'h4);
    wr_reg(8'h11, 8'h11);
    u_uep_host_model.in_ev(2'h0, 4'h1);
    #1;
    chk({7'h00, in_stall_ans}, 8'h01);
    rd_chk(8'h11, 8'h30);
    rd_chk(8'h11, 8'h10);
    wr_reg(8'h12, 8'h40);
    u_uep_host_model.in_ev(2'h0, 4'h1);
    #1;
    chk({6'h00, in_stall_ans, in_zlp_ans}, 8'h01);
    rd_chk(8'h11, 8'h14);
    wr_reg(8'h11, 8'h00);
    wr_reg(8'h12, 8'h00);
    $display("test in answers done");
  endtask

  task automatic t_in_fifo();
    u_uep_host_model.in_ev(2'h0, 4'h4);
    u_uep_host_model.in_ev(2'h0, 4'h4);
    rd_chk(8'h11, 8'h02);
    wr_reg(8'h11, 8'h08);
    rd_chk(8'h11, 8'h02);
    wr_reg(8'h11, 8'h08);
    rd_chk(8'h11, 8'h00);
    u_uep_host_model.in_ev(2'h0, 4'h4);
    wr_reg(8'h11, 8'h01);
    rd_chk(8'h11, 8'h03);
    u_uep_host_model.in_ev(2'h0, 4'h2);
    #1;
    chk({4'h0, in_done_irq, in_toggle}, 8'h09);
    rd_chk(8'h11, 8'h00);
    wr_reg(8'h11, 8'h40);
    #1;
    chk({5'h00, in_toggle}, 8'h00);
    wr_reg(8'h12, 8'h80);
    u_uep_host_model.in_ev(2'h0, 4'hC);
    rd_chk(8'h11, 8'h03);
    wr_reg(8'h11, 8'h08);
    wr_reg(8'h12, 8'h00);
    u_uep_host_model.in_ev(2'h0, 4'h4);
    wr_reg(8'h12, 8'h08);
    #1;
    chk({5'h00, in_toggle}, 8'h01);
    rd_chk(8'h11, 8'h00);
    wr_reg(8'h12, 8'h00);
    $display("test in fifo done");
  endtask

  task automatic t_in_copies();
    wr_reg(8'h0E, 8'h02);
    wr_reg(8'h12, 8'h30);
    rd_chk(8'h12, 8'h30);
    chk({2'h0, in_dir, in_dma_req}, 8'h12);
    wr_reg(8'h12, 8'h20);
    rd_chk(8'h12, 8'h20);
    chk({5'h00, in_dma_req}, 8'h00);
    wr_reg(8'h0E, 8'h01);
    rd_chk(8'h12, 8'h00);
    $display("test in copies done");
  endtask

  task automatic t_out();
    wr_reg(8'h15, 8'h40);
    u_uep_host_model.out_ev(2'h0, 4'h6);
    #1;
    chk({4'h0, out_rcvd_irq, out_toggle}, 8'h09);
    rd_chk(8'h14, 8'h09);
    u_uep_host_model.out_ev(2'h0, 4'h2);
    // error bit follows the latest stored packet, which was clean
    rd_chk(8'h14, 8'h03);
    u_uep_host_model.out_ev(2'h0, 4'h2);
    rd_chk(8'h14, 8'h07);
    wr_reg(8'h14, 8'h10);
    wr_reg(8'h14, 8'h10);
    wr_reg(8'h14, 8'h00);
    rd_chk(8'h14, 8'h00);
    u_uep_host_model.out_ev(2'h0, 4'h2);
    wr_reg(8'h14, 8'h80);
    #1;
    chk({5'h00, out_toggle}, 8'h00);
    wr_reg(8'h14, 8'h10);
    wr_reg(8'h15, 8'h00);
    wr_reg(8'h14, 8'h20);
    u_uep_host_model.out_ev(2'h0, 4'h1);
    #1;
    chk({7'h00, out_stall_ans}, 8'h01);
    rd_chk(8'h14, 8'h60);
    rd_chk(8'h14, 8'h20);
    wr_reg(8'h15, 8'h40);
    u_uep_host_model.out_ev(2'h0, 4'h1);
    #1;
    chk({7'h00, out_stall_ans}, 8'h00);
    wr_reg(8'h14, 8'h00);
    // bulk mode with both packet slots taken: token must be refused
    wr_reg(8'h15, 8'h00);
    u_uep_host_model.out_ev(2'h0, 4'h2);
    u_uep_host_model.out_ev(2'h0, 4'h2);
    u_uep_host_model.out_ev(2'h0, 4'h1);
    #1;
    chk({7'h00, out_nak_ans}, 8'h01);
    rd_chk(8'h14, 8'h03);
    wr_reg(8'h14, 8'h10);
    wr_reg(8'h14, 8'h10);
    rd_chk(8'h14, 8'h00);
    $display("test out done");
  endtask

  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_select();
    t_in_answers();
    t_in_fifo();
    t_in_copies();
    t_out();
    wrap_up();
  end

  // hang guard: far above the length of the whole sequence
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
